/* File: qhp_pkg.sv */
/*
 * Shared constants and types for the quad channel host bus port.
 * Assumes one 100 MHz clock and host pins already synchronous to it.
 */
`default_nettype none

package qhp_pkg;

	// ****************************************************************
	// Pin levels and codes
	// ****************************************************************
	localparam logic       STYLE_STROBE = 1'b1;
	localparam logic       DIR_READ     = 1'b1;
	localparam int         REG_AW       = 3;
	localparam int         DATA_W       = 8;
	localparam int         CHAN_W       = 2;
	localparam int         NUM_CHAN     = 4;
	localparam logic [1:0] CHAN_A       = 2'h0;
	localparam logic [1:0] CHAN_B       = 2'h1;
	localparam logic [1:0] CHAN_C       = 2'h2;
	localparam logic [1:0] CHAN_D       = 2'h3;
	localparam logic [7:0] DATA_RST     = 8'h00;
	localparam logic [2:0] ADDR_RST     = 3'h0;
	localparam int         EDGE_IDX_RD  = 0;
	localparam int         EDGE_IDX_WR  = 1;
	localparam int         EDGE_IDX_CS  = 2;
	localparam int         NUM_EDGE     = 3;

	// ****************************************************************
	// Access sequencer states
	// ****************************************************************
	typedef enum logic [1:0] {
		QHP_IDLE  = 2'b00,
		QHP_READ  = 2'b01,
		QHP_WRITE = 2'b10
	} qhp_state_t;

endpackage

`default_nettype wire

/* File: qhp_edge.sv */
/*
 * Edge detector for one active-low host control pin.
 * Assumes the pin is synchronous to clk; reset value is the idle high.
 */
`timescale 1ns/1ns
`default_nettype none

module qhp_edge (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic pin_n,
	output logic      fall,
	output logic      rise
);

	logic prev_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= pin_n;
		end
	end

	assign fall = prev_q & ~pin_n;
	assign rise = ~prev_q & pin_n;

endmodule

`default_nettype wire

/* File: qhp_port.sv */
/*
 * Host parallel bus port of a four channel UART: decodes the host pins in
 * either bus style into single-cycle register read and write requests.
 * Assumes the channel register set answers acc_rdata combinationally from
 * acc_chan and acc_addr, and that all host pins are synchronous to clk.
 */
// Behaviour
// - Register address picks register in channel.
// - Data bus driven only during reads.
// - Style pin high strobes, low direction.
// - Read strobe fall reads, drives byte.
// - Write strobe fall starts, rise loads.
// - Direction style: write pin high reads.
// - Strobe style: select A enables A.
// - Direction style: select A is chip select.
// - Strobe style: B, C, D own selects.
// - Direction style: B, C pick channel.
// - Direction style: A interrupt open-drain low.
`timescale 1ns/1ns
`default_nettype none

module qhp_port
	import qhp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        bus_style,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic        chan_a_select_n,
	input  wire logic        chan_b_select_n,
	input  wire logic        chan_c_select_n,
	input  wire logic        chan_d_select_n,
	output logic             acc_rd,
	output logic             acc_wr,
	output logic      [1:0]  acc_chan,
	output logic      [2:0]  acc_addr,
	output logic      [7:0]  acc_wdata,
	input  wire logic [7:0]  acc_rdata,
	input  wire logic [3:0]  chan_irq,
	input  wire logic        int_a_en,
	output logic             chan_a_int_out,
	output logic             chan_a_int_oe
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	// Lowest active select wins; a host driving two selects at once is
	// a system fault, and fixed priority keeps the result predictable.
	function automatic logic [1:0] strobe_chan(input logic [3:0] sel_n);
		logic [1:0] c;
		c = CHAN_D;
		if (!sel_n[2]) begin
			c = CHAN_C;
		end
		if (!sel_n[1]) begin
			c = CHAN_B;
		end
		if (!sel_n[0]) begin
			c = CHAN_A;
		end
		return c;
	endfunction

	qhp_state_t    state_q;
	logic [2:0]    pin_n;
	logic [2:0]    fall;
	logic [2:0]    rise;
	logic [3:0]    sel_n;
	logic          strobe_mode;
	logic          any_sel;
	logic          rd_start;
	logic          wr_start;
	logic          rd_end;
	logic          wr_end;
	logic [1:0]    chan_d;
	logic          rd_pend_q;

	assign strobe_mode = (bus_style == STYLE_STROBE);
	assign sel_n = {chan_d_select_n, chan_c_select_n,
			chan_b_select_n, chan_a_select_n};
	assign any_sel = ~&sel_n;
	// The read strobe is never looked at in direction style.
	assign pin_n[EDGE_IDX_RD] = read_strobe_n | ~strobe_mode;
	assign pin_n[EDGE_IDX_WR] = write_strobe_n;
	assign pin_n[EDGE_IDX_CS] = chan_a_select_n;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EDGE; gi++) begin : g_edge
			qhp_edge u_edge (
				.clk   (clk),
				.nrst  (nrst),
				.pin_n (pin_n[gi]),
				.fall  (fall[gi]),
				.rise  (rise[gi])
			);
		end
	endgenerate

	always_comb begin
		if (strobe_mode) begin
			chan_d   = strobe_chan(sel_n);
			rd_start = fall[EDGE_IDX_RD] & any_sel;
			wr_start = fall[EDGE_IDX_WR] & any_sel;
			rd_end   = rise[EDGE_IDX_RD] | ~any_sel;
			wr_end   = rise[EDGE_IDX_WR];
		end else begin
			chan_d   = {chan_c_select_n, chan_b_select_n};
			rd_start = fall[EDGE_IDX_CS] &
				(write_strobe_n == DIR_READ);
			wr_start = fall[EDGE_IDX_CS] &
				(write_strobe_n != DIR_READ);
			rd_end   = chan_a_select_n;
			wr_end   = rise[EDGE_IDX_CS];
		end
	end

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= QHP_IDLE;
		end else begin
			case (state_q)
				QHP_IDLE: begin
					if (rd_start) begin
						state_q <= QHP_READ;
					end else if (wr_start) begin
						state_q <= QHP_WRITE;
					end
				end
				QHP_READ: begin
					if (rd_end) begin
						state_q <= QHP_IDLE;
					end
				end
				QHP_WRITE: begin
					if (wr_end) begin
						state_q <= QHP_IDLE;
					end
				end
				default: begin
					state_q <= QHP_IDLE;
				end
			endcase
		end
	end

	// Channel and register are frozen at the start of the access.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_chan <= CHAN_A;
			acc_addr <= ADDR_RST;
		end else if (state_q == QHP_IDLE && (rd_start || wr_start)) begin
			acc_chan <= chan_d;
			acc_addr <= reg_addr;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_rd    <= 1'b0;
			rd_pend_q <= 1'b0;
		end else begin
			acc_rd    <= (state_q == QHP_IDLE) && rd_start;
			rd_pend_q <= acc_rd;
		end
	end

	// Write data is taken on the closing edge, when the host has had the
	// whole strobe low time to settle the bus.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_wr    <= 1'b0;
			acc_wdata <= DATA_RST;
		end else begin
			acc_wr <= (state_q == QHP_WRITE) && wr_end;
			if ((state_q == QHP_WRITE) && wr_end) begin
				acc_wdata <= data_in;
			end
		end
	end

	// ****************************************************************
	// Data bus drive
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_out <= DATA_RST;
			data_oe  <= 1'b0;
		end else begin
			if (acc_rd) begin
				data_out <= acc_rdata;
			end
			data_oe <= (state_q == QHP_READ) && !rd_end &&
				(acc_rd || data_oe);
		end
	end

	// ****************************************************************
	// Interrupt pin
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chan_a_int_out <= 1'b0;
			chan_a_int_oe  <= 1'b0;
		end else if (strobe_mode) begin
			chan_a_int_out <= chan_irq[CHAN_A];
			chan_a_int_oe  <= int_a_en;
		end else begin
			chan_a_int_out <= 1'b0;
			chan_a_int_oe  <= |chan_irq;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_rd_begin;
		state_q == QHP_IDLE && rd_start;
	endsequence

	sequence s_rd_drive;
		acc_rd ##1 (data_oe || $past(rd_end));
	endsequence

	a_read_pulse_drive: assert property (
		s_rd_begin |=> s_rd_drive)
		else $error("read start did not pulse and drive the bus");

	a_bus_read_only: assert property (
		data_oe |-> state_q == QHP_READ)
		else $error("data bus driven outside a read");

	a_read_data_held: assert property (
		data_oe && $past(data_oe) |-> $stable(data_out))
		else $error("read byte changed while driven");

	a_write_commit: assert property (
		state_q == QHP_WRITE && wr_end |=>
			acc_wr && acc_wdata == $past(data_in))
		else $error("write byte not committed at strobe rise");

	a_write_only_commit: assert property (
		acc_wr |-> $past(state_q) == QHP_WRITE)
		else $error("write pulse without a write access");

	a_addr_latched: assert property (
		(state_q == QHP_IDLE && (rd_start || wr_start)) |=>
			acc_addr == $past(reg_addr))
		else $error("register address not latched");

	a_dir_chan_pick: assert property (
		!strobe_mode && state_q == QHP_IDLE && fall[EDGE_IDX_CS] |=>
			acc_chan == $past({chan_c_select_n, chan_b_select_n}))
		else $error("channel address lines not honoured");

	a_dir_rw_level: assert property (
		!strobe_mode && state_q == QHP_IDLE && fall[EDGE_IDX_CS] &&
			!write_strobe_n |=> state_q == QHP_WRITE && !acc_rd)
		else $error("low direction level did not start a write");

	a_strobe_needs_sel: assert property (
		strobe_mode && all_desel() |=> !acc_rd && !acc_wr)
		else $error("access started with no channel selected");

	a_dir_int_drain: assert property (
		!strobe_mode && $past(!strobe_mode) |->
			!chan_a_int_out && chan_a_int_oe == $past(|chan_irq))
		else $error("device interrupt not open-drain low");

	function automatic logic all_desel();
		return &sel_n && state_q == QHP_IDLE;
	endfunction

endmodule

`default_nettype wire

/* File: qhp_host.sv */
/*
 * Host processor model for the quad channel host bus port.
 * Assumes the bench resolves the data bus and drives the bus style pin.
 */
`timescale 1ns/1ns
`default_nettype none

module qhp_host (
	input  wire logic       clk,
	input  wire logic       bus_style,
	input  wire logic [7:0] data_in,
	input  wire logic       data_oe,
	output logic      [2:0] reg_addr,
	output logic      [7:0] host_data,
	output logic            host_oe,
	output logic            read_strobe_n,
	output logic            write_strobe_n,
	output logic      [3:0] sel_n
);
	initial begin
		{reg_addr, host_data, host_oe} = '0;
		{read_strobe_n, write_strobe_n, sel_n} = '1;
	end

	// In strobe style, bit 2 of ch set means no select at all, to provoke a refusal.
	task automatic acc(input logic w, input logic [2:0] ch,
		input logic [2:0] a, inout logic [7:0] d, output logic ok);
		int n;
		ok = 1'b1;
		@(posedge clk);
		reg_addr <= a;
		host_data <= d;
		host_oe <= w;
		write_strobe_n <= !w;
		if (bus_style) begin
			sel_n <= ch[2] ? 4'hF : ~(4'h1 << ch[1:0]);
			read_strobe_n <= w;
		end else begin
			sel_n <= {1'b1, ch[1:0], 1'b0};
			read_strobe_n <= 1'b1;
		end
		if (!w) begin
			for (n = 0; n < 20 && data_oe !== 1'b1; n++)
				@(posedge clk);
			ok = (data_oe === 1'b1);
		end else
			repeat (3) @(posedge clk);
		@(posedge clk);
		d = data_in;
		if (bus_style)
			{read_strobe_n, write_strobe_n} <= 2'h3;
		else
			sel_n[0] <= 1'b1;
		@(posedge clk);
		sel_n <= 4'hF;
		{read_strobe_n, write_strobe_n} <= 2'h3;
		host_oe <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
endmodule

`default_nettype wire

/* File: test_quad_uart_host_bus_port.sv */
/*
 * Self-checking bench for the quad channel host bus port.
 * Assumes a host model drives the pins and the bench holds the registers.
 */
`timescale 1ns/1ns
`default_nettype none

module test_quad_uart_host_bus_port;
	import qhp_pkg::*;
	logic       clk      = 1'b0;
	logic       nrst     = 1'b0;
	logic       bus_style = STYLE_STROBE;
	logic [3:0] chan_irq = 4'h0;
	logic       int_a_en = 1'b0;
	logic [7:0] flt      = 8'hA5;
	logic [7:0] data_in, data_out, acc_wdata, acc_rdata, host_data;
	logic [2:0] reg_addr, acc_addr;
	logic [1:0] acc_chan;
	logic [3:0] sel_n;
	logic       data_oe, acc_rd, acc_wr, host_oe, chan_a_int_out;
	logic       chan_a_int_oe, read_strobe_n, write_strobe_n;
	logic [7:0] store [32];
	int         ref_mem [32];
	int         miscompares = 0;
	int         tests_run = 0;

	always #5 clk = ~clk;
	// A released bus keeps changing, so a stale byte can never pass.
	always @(posedge clk) flt <= ~flt;
	always @(posedge clk) if (acc_wr === 1'b1) store[{acc_chan, acc_addr}] <= acc_wdata;
	assign acc_rdata = store[{acc_chan, acc_addr}];
	assign data_in = host_oe ? host_data : (data_oe ? data_out : flt);

	qhp_port u_dut (.clk, .nrst, .bus_style, .reg_addr, .data_in, .data_out,
		.data_oe, .read_strobe_n, .write_strobe_n,
		.chan_a_select_n(sel_n[0]), .chan_b_select_n(sel_n[1]),
		.chan_c_select_n(sel_n[2]), .chan_d_select_n(sel_n[3]),
		.acc_rd, .acc_wr, .acc_chan, .acc_addr, .acc_wdata, .acc_rdata,
		.chan_irq, .int_a_en, .chan_a_int_out, .chan_a_int_oe);
	qhp_host u_host (.clk, .bus_style, .data_in, .data_oe, .reg_addr,
		.host_data, .host_oe, .read_strobe_n, .write_strobe_n, .sel_n);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic xfer(input logic w, input logic [1:0] ch,
		input logic [2:0] a, inout logic [7:0] d);
		logic ok;
		u_host.acc(w, {1'b0, ch}, a, d, ok);
		if (!ok) begin
			miscompares++;
			$display("MISMATCH t=%0t read wait ran out", $time);
			end_of_test();
		end
		chk(8'(data_oe), 8'h00, "bus left driven");
	endtask

	initial begin
		logic [7:0] d;
		logic [1:0] ch;
		logic [2:0] a;
		logic       ok;
		int         i, s;
		void'($urandom(22));
		for (i = 0; i < 32; i++) begin
			store[i] = 8'($urandom);
			ref_mem[i] = store[i];
		end
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({data_oe, acc_rd, acc_wr, chan_a_int_oe, 4'h0}, 8'h00, "reset");
		for (s = 0; s < 2; s++) begin
			bus_style <= (s == 0) ? STYLE_STROBE : !STYLE_STROBE;
			repeat (2) @(posedge clk);
			for (i = 0; i < 16; i++) begin
				ch = i[1:0];
				a = 3'($urandom);
				d = 8'($urandom);
				ref_mem[{ch, a}] = d;
				xfer(1'b1, ch, a, d);
				ch = 2'(i + 1);
				a = 3'($urandom);
				xfer(1'b0, ch, a, d);
				chk(d, 8'(ref_mem[{ch, a}]), "read back");
			end
			chan_irq <= 4'h1 << 2'($urandom);
			int_a_en <= 1'($urandom);
			repeat (3) @(posedge clk);
			chk(8'({chan_a_int_out, chan_a_int_oe}), (s == 0) ?
				8'({chan_irq[0], int_a_en}) : 8'({1'b0, |chan_irq}), "irq pin");
			if (s == 0) begin
				u_host.acc(1'b0, 3'h4, 3'h0, d, ok);
				chk(8'(ok), 8'h00, "unselected strobe answered");
			end
			$display("test style %0d done", s);
		end
		end_of_test();
	end
endmodule

`default_nettype wire
